// ### bench/scfg_config_core_bench.sv
// Self-checking bench for the config core with a host model.
// Assumes a 10 MHz core clock; inputs change 1 ns after rising edges.
`timescale 1ns/100ps
module scfg_config_core_bench;
  logic core_clk, rst_n, ce, regWrEn, regRdEn, burstStart, burstNext;
  logic burstStop, byteOrderSel, tempInAutoinc, fastRead, burstActive;
  logic [7:0] regAddr, regWrData, regRdData, rateReg, cfgValue, rdPtr;
  logic [7:0] fmtByte, rdv;
  logic [11:0] sampleWord, wakeIdle, sleepIdle;
  scfg_pkg::scfg_pmode_type wakePowerSel, sleepPowerSel;
  logic [3:0] wakeRateCode, wakeDecimationCode;
  logic [3:0] sleepRateCode, sleepDecimationCode;
  logic [27:0] wakePeriod, sleepPeriod;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  scfg_config_core scfg_config_core_i (.core_clk, .rst_n, .ce, .regAddr,
    .regWrEn, .regWrData, .regRdEn, .regRdData, .burstStart, .burstNext,
    .burstStop, .sampleWord, .rateReg, .wakeIdle, .sleepIdle, .cfgValue,
    .wakePowerSel, .sleepPowerSel, .wakeRateCode, .wakeDecimationCode,
    .sleepRateCode, .sleepDecimationCode, .wakePeriod, .sleepPeriod,
    .byteOrderSel, .tempInAutoinc, .fastRead, .burstActive, .rdPtr,
    .fmtByte);
  scfg_host_model scfg_host_model_i (.core_clk, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic stop_test;
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [27:0] e,
    input logic [27:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #1;
    s = 1'b1;
    @(posedge core_clk);
    #1;
    s = 1'b0;
  endtask
  task automatic go(input logic [7:0] a);
    scfg_host_model_i.point(a);
    pulse(burstStart);
  endtask
  task automatic fmt(input logic [7:0] a, input logic [7:0] e);
    go(a);
    @(posedge core_clk);
    #1;
    chk("fmtByte", 28'(e), 28'(fmtByte));
  endtask
  task automatic step(input logic [7:0] e);
    pulse(burstNext);
    chk("rdPtr", 28'(e), 28'(rdPtr));
  endtask
  task automatic t_reset;
    scfg_host_model_i.rd(8'h16, rdv);
    chk("cfgRead", 28'h0, 28'(rdv));
    chk("wakeSel", 28'h0, 28'(wakePowerSel));
  endtask
  task automatic t_mask;
    scfg_host_model_i.wr(8'h16, 8'hFF);
    scfg_host_model_i.wr(8'h17, 8'h00);
    ce = 1'b0;
    scfg_host_model_i.wr(8'h16, 8'h00);
    ce = 1'b1;
    scfg_host_model_i.rd(8'h16, rdv);
    chk("cfgRead", 28'hFB, 28'(rdv));
    scfg_host_model_i.rd(8'h20, rdv);
    chk("unmapped", 28'h0, 28'(rdv));
  endtask
  task automatic t_modes;
    logic f;
    for (int i = 0; i < 4; i++) begin
      f = i[1];
      scfg_host_model_i.wr(8'h16, {i[1:0], i[1:0], 4'h0});
      @(posedge core_clk);
      #1;
      chk("wakeSel", f ? 28'h2 : 28'(i[1:0]), 28'(wakePowerSel));
      chk("sleepSel", f ? 28'h2 : 28'(i[1:0]), 28'(sleepPowerSel));
      chk("wakeRate", f ? 28'h0 : 28'hA, 28'(wakeRateCode));
      chk("wakeDec", f ? 28'hA : 28'h0, 28'(wakeDecimationCode));
      chk("sleepRate", f ? 28'h0 : 28'h5, 28'(sleepRateCode));
      chk("sleepDec", f ? 28'h5 : 28'h0, 28'(sleepDecimationCode));
      chk("wakePeriod", f ? 28'h1000 : 28'h0, wakePeriod);
      chk("sleepPeriod", f ? 28'h220 : 28'h0, sleepPeriod);
    end
  endtask
  task automatic t_format;
    scfg_host_model_i.wr(8'h16, 8'h00);
    fmt(8'h04, 8'hBC);
    fmt(8'h05, 8'h0A);
    scfg_host_model_i.wr(8'h16, 8'h08);
    chk("byteOrder", 28'h1, 28'(byteOrderSel));
    fmt(8'h0E, 8'hAB);
    fmt(8'h0B, 8'hC0);
    fmt(8'h02, 8'hBC);
    scfg_host_model_i.wr(8'h16, 8'h01);
    chk("fastRead", 28'h1, 28'(fastRead));
    fmt(8'h10, 8'hAB);
    // Fast read must ignore the byte order bit
    scfg_host_model_i.wr(8'h16, 8'h09);
    fmt(8'h11, 8'h00);
    fmt(8'h04, 8'hAB);
  endtask
  task automatic t_skip;
    go(8'h04);
    step(8'h06);
    step(8'h08);
    go(8'h0E);
    step(8'h10);
    go(8'h0A);
    step(8'h0B);
    go(8'h00);
    step(8'h02);
    scfg_host_model_i.wr(8'h16, 8'h02);
    chk("tempInc", 28'h1, 28'(tempInAutoinc));
    go(8'h04);
    step(8'h05);
    go(8'h00);
    step(8'h01);
    pulse(burstStop);
    chk("burstActive", 28'h0, 28'(burstActive));
  endtask
  task automatic t_midreset;
    scfg_host_model_i.wr(8'h16, 8'hCF);
    go(8'h04);
    chk("cfgValue", 28'hCB, 28'(cfgValue));
    chk("wakeSel", 28'h2, 28'(wakePowerSel));
    rst_n = 1'b0;
    @(posedge core_clk);
    #1;
    chk("cfgValue", 28'h0, 28'(cfgValue));
    chk("wakeSel", 28'h0, 28'(wakePowerSel));
    chk("burstActive", 28'h0, 28'(burstActive));
    chk("rdPtr", 28'h0, 28'(rdPtr));
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    scfg_host_model_i.rd(8'h16, rdv);
    chk("cfgRead", 28'h0, 28'(rdv));
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    burstStart = 1'b0;
    burstNext = 1'b0;
    burstStop = 1'b0;
    sampleWord = 12'hABC;
    rateReg = 8'hA5;
    wakeIdle = 12'h003;
    sleepIdle = 12'h010;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_mask();
    t_modes();
    t_format();
    t_skip();
    t_midreset();
    stop_test();
  end
endmodule // scfg_config_core_bench

// ### bench/scfg_config_props.sv
// Checker for the config core, watching its top ports only.
// Assumes one core clock and an async active-low reset.
`timescale 1ns/100ps
module scfg_config_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic burstStart,
  input wire logic burstNext,
  input wire logic burstStop,
  input wire logic [7:0] rateReg,
  input wire logic [scfg_pkg::IDLE_W-1:0] wakeIdle,
  input wire logic [7:0] cfgValue,
  input wire scfg_pkg::scfg_pmode_type wakePowerSel,
  input wire scfg_pkg::scfg_pmode_type sleepPowerSel,
  input wire logic [scfg_pkg::CODE_W-1:0] wakeRateCode,
  input wire logic [scfg_pkg::CODE_W-1:0] wakeDecimationCode,
  input wire logic [scfg_pkg::CODE_W-1:0] sleepDecimationCode,
  input wire logic [scfg_pkg::PERIOD_W-1:0] wakePeriod,
  input wire logic fastRead,
  input wire logic tempInAutoinc,
  input wire logic burstActive,
  input wire logic [7:0] rdPtr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire wrCfg = ce && regWrEn && regAddr == scfg_pkg::CFG_ADDR;
  wire rdCfg = ce && regRdEn && regAddr == scfg_pkg::CFG_ADDR;
  wire adv = ce && burstActive && burstNext && !burstStart && !burstStop;
  cfg_write_a: assert property (wrCfg |=>
    cfgValue == ($past(regWrData) & 8'hFB)) else $error("bad cfg write");
  unused_bit_a: assert property (cfgValue[2] == 1'b0)
    else $error("bit 2 set");
  cfg_read_a: assert property (rdCfg |=>
    regRdData == $past(cfgValue)) else $error("bad cfg read");
  wake_lp_a: assert property (ce && cfgValue[7:6] == 2'b00 |=>
    wakePowerSel == scfg_pkg::SCFG_LOW_POWER) else $error("wake not low");
  sleep_lp_a: assert property (ce && cfgValue[5:4] == 2'b00 |=>
    sleepPowerSel == scfg_pkg::SCFG_LOW_POWER) else $error("sleep not low");
  wake_hp_a: assert property (ce && cfgValue[7:6] == 2'b01 |=>
    wakePowerSel == scfg_pkg::SCFG_HIGH_PERF &&
    wakeRateCode == $past(rateReg[7:4])) else $error("wake hp decode");
  wake_flex_a: assert property (ce && cfgValue[7] |=>
    wakePowerSel == scfg_pkg::SCFG_FLEXIBLE &&
    wakeDecimationCode == $past(rateReg[7:4]) &&
    wakePeriod == (28'($past(wakeIdle)) + 28'h1) << $past(rateReg[7:4]))
    else $error("wake flex decode");
  sleep_flex_a: assert property (ce && cfgValue[5] |=>
    sleepPowerSel == scfg_pkg::SCFG_FLEXIBLE &&
    sleepDecimationCode == $past(rateReg[3:0])) else $error("sleep flex");
  fast_skip_a: assert property (adv && fastRead &&
    rdPtr inside {8'h04, 8'h06, 8'h08, 8'h0E, 8'h10, 8'h12} |=>
    rdPtr == $past(rdPtr) + 8'h02) else $error("fast skip wrong");
  temp_skip_a: assert property (adv && !tempInAutoinc &&
    rdPtr == 8'h00 |=> rdPtr == 8'h02) else $error("temp not skipped");
  cover property (wrCfg);
  cover property (rdCfg);
  cover property (adv && fastRead);
  cover property (ce && cfgValue[7] && cfgValue[5]);
endmodule // scfg_config_props

bind scfg_config_core scfg_config_props scfg_config_props_i (.core_clk,
  .rst_n, .ce, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
  .burstStart, .burstNext, .burstStop, .rateReg, .wakeIdle, .cfgValue,
  .wakePowerSel, .sleepPowerSel, .wakeRateCode, .wakeDecimationCode,
  .sleepDecimationCode, .wakePeriod, .fastRead, .tempInAutoinc,
  .burstActive, .rdPtr);

// ### bench/scfg_host_model.sv
// Host model: drives the register port of the config core.
// Assumes the core clock; requests change 1 ns after a rising edge.
`timescale 1ns/100ps
module scfg_host_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  task automatic point(input logic [7:0] a);
    regAddr = a;
  endtask
  // writes at any time, not only in standby; the bench also writes while a burst is active
  // Writes are not held off during a burst; t_format and t_skip write with burstActive set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #1;
    regWrEn = 1'b0;
    // Released data lines must not hold a stale value
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule // scfg_host_model

// ### verilog/scfg_config_core.sv
// Power-mode and output-format configuration register with read formatter.
// Assumes a synchronous byte register port and sample words supplied
// for the pair that holds the current read pointer.
`timescale 1ns/100ps
module scfg_config_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic burstStart,
  input wire logic burstNext,
  input wire logic burstStop,
  input wire logic [11:0] sampleWord,
  input wire logic [7:0] rateReg,
  input wire logic [scfg_pkg::IDLE_W-1:0] wakeIdle,
  input wire logic [scfg_pkg::IDLE_W-1:0] sleepIdle,
  output logic [7:0] cfgValue,
  output scfg_pkg::scfg_pmode_type wakePowerSel,
  output scfg_pkg::scfg_pmode_type sleepPowerSel,
  output logic [scfg_pkg::CODE_W-1:0] wakeRateCode,
  output logic [scfg_pkg::CODE_W-1:0] wakeDecimationCode,
  output logic [scfg_pkg::CODE_W-1:0] sleepRateCode,
  output logic [scfg_pkg::CODE_W-1:0] sleepDecimationCode,
  output logic [scfg_pkg::PERIOD_W-1:0] wakePeriod,
  output logic [scfg_pkg::PERIOD_W-1:0] sleepPeriod,
  output logic byteOrderSel,
  output logic tempInAutoinc,
  output logic fastRead,
  output logic burstActive,
  output logic [7:0] rdPtr,
  output logic [7:0] fmtByte
);

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdData;
    scfg_pkg::scfg_rdstate_type rdState;
    logic [7:0] ptr;
    logic [7:0] fmt;
    scfg_pkg::scfg_pmode_type wakeSel;
    scfg_pkg::scfg_pmode_type sleepSel;
    logic [scfg_pkg::CODE_W-1:0] wakeRate;
    logic [scfg_pkg::CODE_W-1:0] wakeDec;
    logic [scfg_pkg::CODE_W-1:0] sleepRate;
    logic [scfg_pkg::CODE_W-1:0] sleepDec;
    logic [scfg_pkg::PERIOD_W-1:0] wakePer;
    logic [scfg_pkg::PERIOD_W-1:0] sleepPer;
  } scfg_state_type;

  localparam scfg_state_type STATE_RESET = '{
    cfg: scfg_pkg::CFG_RESET,
    rdData: 8'h00,
    rdState: scfg_pkg::SCFG_RD_IDLE,
    ptr: 8'h00,
    fmt: 8'h00,
    wakeSel: scfg_pkg::SCFG_LOW_POWER,
    sleepSel: scfg_pkg::SCFG_LOW_POWER,
    wakeRate: 4'h0,
    wakeDec: 4'h0,
    sleepRate: 4'h0,
    sleepDec: 4'h0,
    wakePer: '0,
    sleepPer: '0
  };

  scfg_state_type st;
  scfg_state_type next_st;

  // Axis data: current output and buffer, both formatted and skippable
  function automatic logic is_axis(input logic [7:0] addr);
    return ((addr >= scfg_pkg::OUT_FIRST) &&
            (addr <= scfg_pkg::OUT_LAST)) ||
           ((addr >= scfg_pkg::BUF_FIRST) &&
            (addr <= scfg_pkg::BUF_LAST));
  endfunction

  function automatic logic is_formatted(input logic [7:0] addr);
    return is_axis(addr) ||
           ((addr >= scfg_pkg::MAG_FIRST) &&
            (addr <= scfg_pkg::MAG_LAST));
  endfunction

  // Pairs start on even addresses; bit 0 marks the upper address
  function automatic logic [7:0] format_byte(
    input logic [11:0] s,
    input logic [7:0] addr,
    input logic [7:0] cfg
  );
    logic upper;
    upper = addr[0];
    if (!is_formatted(addr)) begin
      return upper ? {4'h0, s[11:8]} : s[7:0];
    end
    if (cfg[scfg_pkg::FAST_READ_BIT]) begin
      return upper ? 8'h00 : s[11:4];
    end
    if (cfg[scfg_pkg::BYTE_ORDER_BIT]) begin
      return upper ? {s[3:0], 4'h0} : s[11:4];
    end
    return upper ? {4'h0, s[11:8]} : s[7:0];
  endfunction

  function automatic logic [7:0] advance_ptr(
    input logic [7:0] addr,
    input logic [7:0] cfg
  );
    logic [7:0] nxt;
    nxt = addr + 8'h01;
    if (cfg[scfg_pkg::FAST_READ_BIT] && is_axis(addr) && !addr[0]) begin
      nxt = addr + 8'h02;
    end
    if ((nxt == scfg_pkg::TEMP_ADDR) && !cfg[scfg_pkg::TEMP_INC_BIT]) begin
      nxt = nxt + 8'h01;
    end
    return nxt;
  endfunction

  scfg_mode_if modeBus ();

  assign modeBus.cfgBits = st.cfg;
  assign modeBus.rateReg = rateReg;
  assign modeBus.wakeIdle = wakeIdle;
  assign modeBus.sleepIdle = sleepIdle;

  scfg_mode_decode u_decode (
    .mode(modeBus.decoder)
  );

  always_comb begin
    next_st = st;
    // Write path: bit 2 has no storage behind it
    if (regWrEn && (regAddr == scfg_pkg::CFG_ADDR)) begin
      next_st.cfg = regWrData & scfg_pkg::CFG_WRITE_MASK;
    end
    // Read path; other addresses belong to neighbouring blocks
    if (regRdEn) begin
      if (regAddr == scfg_pkg::CFG_ADDR) begin
        next_st.rdData = st.cfg;
      end else begin
        next_st.rdData = 8'h00;
      end
    end
    // Mode decode held in flops so outputs stay glitch free
    next_st.wakeSel = modeBus.wakeSel;
    next_st.sleepSel = modeBus.sleepSel;
    next_st.wakeRate = modeBus.wakeRate;
    next_st.wakeDec = modeBus.wakeDec;
    next_st.sleepRate = modeBus.sleepRate;
    next_st.sleepDec = modeBus.sleepDec;
    next_st.wakePer = modeBus.wakePeriod;
    next_st.sleepPer = modeBus.sleepPeriod;
    // Burst pointer; a start always wins, so a stuck burst can be restarted
    case (st.rdState)
      scfg_pkg::SCFG_RD_IDLE: begin
        if (burstStart) begin
          next_st.ptr = regAddr;
          next_st.rdState = scfg_pkg::SCFG_RD_BURST;
        end
      end
      scfg_pkg::SCFG_RD_BURST: begin
        if (burstStart) begin
          next_st.ptr = regAddr;
        end else if (burstStop) begin
          next_st.rdState = scfg_pkg::SCFG_RD_IDLE;
        end else if (burstNext) begin
          next_st.ptr = advance_ptr(st.ptr, st.cfg);
        end
      end
      default: begin
        next_st.rdState = scfg_pkg::SCFG_RD_IDLE;
      end
    endcase
    // Formatted byte for the address now under the pointer
    next_st.fmt = format_byte(sampleWord, st.ptr, st.cfg);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign cfgValue = st.cfg;
  assign wakePowerSel = st.wakeSel;
  assign sleepPowerSel = st.sleepSel;
  assign wakeRateCode = st.wakeRate;
  assign wakeDecimationCode = st.wakeDec;
  assign sleepRateCode = st.sleepRate;
  assign sleepDecimationCode = st.sleepDec;
  assign wakePeriod = st.wakePer;
  assign sleepPeriod = st.sleepPer;
  assign byteOrderSel = st.cfg[scfg_pkg::BYTE_ORDER_BIT];
  assign tempInAutoinc = st.cfg[scfg_pkg::TEMP_INC_BIT];
  assign fastRead = st.cfg[scfg_pkg::FAST_READ_BIT];
  assign burstActive = (st.rdState == scfg_pkg::SCFG_RD_BURST);
  assign rdPtr = st.ptr;
  assign fmtByte = st.fmt;

endmodule // scfg_config_core

// ### verilog/scfg_mode_decode.sv
// Power-mode decoder: splits the rate register by the selected modes.
// Assumes it is purely combinational; the core registers its results.
`timescale 1ns/100ps
module scfg_mode_decode (
  scfg_mode_if.decoder mode
);

  function automatic scfg_pkg::scfg_pmode_type pm_decode(
    input logic [1:0] field
  );
    if (field[1]) begin
      return scfg_pkg::SCFG_FLEXIBLE;
    end else if (field[0]) begin
      return scfg_pkg::SCFG_HIGH_PERF;
    end
    return scfg_pkg::SCFG_LOW_POWER;
  endfunction

  // Period in base ticks: (idle + 1) times a power-of-two decimation
  function automatic logic [scfg_pkg::PERIOD_W-1:0] flex_period(
    input logic [scfg_pkg::IDLE_W-1:0] idle,
    input logic [scfg_pkg::CODE_W-1:0] code
  );
    logic [scfg_pkg::PERIOD_W-1:0] base;
    base = scfg_pkg::PERIOD_W'(idle) + scfg_pkg::PERIOD_W'(1);
    return base << code;
  endfunction

  logic [scfg_pkg::CODE_W-1:0] wakeNib;
  logic [scfg_pkg::CODE_W-1:0] sleepNib;
  logic wakeFlex;
  logic sleepFlex;

  assign wakeNib = mode.rateReg[scfg_pkg::WAKE_NIB_HI:scfg_pkg::WAKE_NIB_LO];
  assign sleepNib =
    mode.rateReg[scfg_pkg::SLEEP_NIB_HI:scfg_pkg::SLEEP_NIB_LO];

  assign mode.wakeSel = pm_decode(
    mode.cfgBits[scfg_pkg::WAKE_SEL_HI:scfg_pkg::WAKE_SEL_LO]);
  assign mode.sleepSel = pm_decode(
    mode.cfgBits[scfg_pkg::SLEEP_SEL_HI:scfg_pkg::SLEEP_SEL_LO]);

  assign wakeFlex = (mode.wakeSel == scfg_pkg::SCFG_FLEXIBLE);
  assign sleepFlex = (mode.sleepSel == scfg_pkg::SCFG_FLEXIBLE);

  // Upper nibble (wake) or lower nibble (sleep) as rate or decimation
  assign mode.wakeRate = wakeFlex ? 4'h0 : wakeNib;
  assign mode.wakeDec = wakeFlex ? wakeNib : 4'h0;
  assign mode.sleepRate = sleepFlex ? 4'h0 : sleepNib;
  assign mode.sleepDec = sleepFlex ? sleepNib : 4'h0;

  assign mode.wakePeriod = wakeFlex ?
    flex_period(mode.wakeIdle, wakeNib) : '0;
  assign mode.sleepPeriod = sleepFlex ?
    flex_period(mode.sleepIdle, sleepNib) : '0;

endmodule // scfg_mode_decode

// ### verilog/scfg_mode_if.sv
// Carrier between the config core and its power-mode decoder.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/100ps
interface scfg_mode_if;
  logic [7:0] cfgBits;
  logic [7:0] rateReg;
  logic [scfg_pkg::IDLE_W-1:0] wakeIdle;
  logic [scfg_pkg::IDLE_W-1:0] sleepIdle;
  scfg_pkg::scfg_pmode_type wakeSel;
  scfg_pkg::scfg_pmode_type sleepSel;
  logic [scfg_pkg::CODE_W-1:0] wakeRate;
  logic [scfg_pkg::CODE_W-1:0] wakeDec;
  logic [scfg_pkg::CODE_W-1:0] sleepRate;
  logic [scfg_pkg::CODE_W-1:0] sleepDec;
  logic [scfg_pkg::PERIOD_W-1:0] wakePeriod;
  logic [scfg_pkg::PERIOD_W-1:0] sleepPeriod;

  modport core (
    output cfgBits, rateReg, wakeIdle, sleepIdle,
    input wakeSel, sleepSel, wakeRate, wakeDec, sleepRate, sleepDec,
    input wakePeriod, sleepPeriod
  );
  modport decoder (
    input cfgBits, rateReg, wakeIdle, sleepIdle,
    output wakeSel, sleepSel, wakeRate, wakeDec, sleepRate, sleepDec,
    output wakePeriod, sleepPeriod
  );
endinterface // scfg_mode_if

// ### verilog/scfg_pkg.sv
// Constants and types for the power-mode and output-format config block.
// Assumes a byte-wide register port and a 10 MHz core clock.
package scfg_pkg;

  // Register location and reset contents
  localparam logic [7:0] CFG_ADDR = 8'h16;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Bit 2 is unused: writes to it are dropped
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFB;

  // Field positions
  localparam int WAKE_SEL_HI = 7;
  localparam int WAKE_SEL_LO = 6;
  localparam int SLEEP_SEL_HI = 5;
  localparam int SLEEP_SEL_LO = 4;
  localparam int BYTE_ORDER_BIT = 3;
  localparam int TEMP_INC_BIT = 1;
  localparam int FAST_READ_BIT = 0;

  // Rate register nibbles
  localparam int WAKE_NIB_HI = 7;
  localparam int WAKE_NIB_LO = 4;
  localparam int SLEEP_NIB_HI = 3;
  localparam int SLEEP_NIB_LO = 0;

  // Widths
  localparam int IDLE_W = 12;
  localparam int CODE_W = 4;
  // (idle + 1) shifted by up to 15 decimation steps
  localparam int PERIOD_W = 28;

  // Output data map used by the read pointer
  localparam logic [7:0] TEMP_ADDR = 8'h01;
  localparam logic [7:0] OUT_FIRST = 8'h04;
  localparam logic [7:0] OUT_LAST = 8'h09;
  localparam logic [7:0] MAG_FIRST = 8'h0A;
  localparam logic [7:0] MAG_LAST = 8'h0B;
  localparam logic [7:0] BUF_FIRST = 8'h0E;
  localparam logic [7:0] BUF_LAST = 8'h13;

  typedef enum logic [1:0] {
    SCFG_LOW_POWER = 2'b00,
    SCFG_HIGH_PERF = 2'b01,
    SCFG_FLEXIBLE = 2'b10
  } scfg_pmode_type;

  typedef enum logic [0:0] {
    SCFG_RD_IDLE = 1'b0,
    SCFG_RD_BURST = 1'b1
  } scfg_rdstate_type;

endpackage
